// ==== common/wdc_regs.svh ====
`ifndef WDC_REGS_SVH
`define WDC_REGS_SVH

// ----------------------------------------
// Register map, byte offsets
// ----------------------------------------
`define WDC_ADDR_STATUS 4'h0
`define WDC_ADDR_CONFIG 4'h4

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define WDC_STAT_ERR 0
`define WDC_STAT_EQ 1
`define WDC_STAT_NEG 2
`define WDC_STAT_BUSY 3
`define WDC_CFG_SHIFT_RST 4'hC

// ----------------------------------------
// Control word limits, raw BCD compare
// ----------------------------------------
`define WDC_NORMAL_MAX 16'h6655
`define WDC_PUSH_MIN 16'h9000
`define WDC_POP_MIN 16'h8000
`define WDC_TOP_FIFO 4'h9
`define WDC_TOP_LIFO 4'h8
`define WDC_BIT_MAX 8'h15
`define WDC_DIGIT_MAX 4'h3

`endif

// ==== common/wdc_pkg.sv ====
package wdc_pkg;
  typedef logic [15:0] wdc_word_t;
  typedef logic [15:0] wdc_addr_t;

  typedef enum logic [1:0] {
    WDC_WORD_DISTRIBUTE,
    WDC_WORD_COLLECT,
    WDC_BIT_MOVE,
    WDC_DIGIT_MOVE
  } wdc_op_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RD_PTR,
    ST_RD_WORD,
    ST_SHIFT_RD,
    ST_SHIFT_WR,
    ST_WR_WORD,
    ST_WR_PTR,
    ST_DONE
  } wdc_fsm_e;

  typedef struct packed {
    wdc_op_e op;
    logic cond;
    wdc_word_t src;
    wdc_addr_t base;
    wdc_word_t ctrl;
    wdc_addr_t dest;
    logic indUse;
    wdc_word_t indPtr;
  } wdc_req_s;

  typedef struct packed {
    logic req;
    logic we;
    wdc_addr_t addr;
    wdc_word_t wdata;
  } wdc_mem_s;

  typedef struct packed {
    logic err;
    logic eq;
    logic neg;
  } wdc_flags_s;
endpackage

// ==== core/wdc_unit.sv ====
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wdc_regs.svh"

// Notes on behaviour
// - Normal distribute writes source to base plus control offset.
// - Control top digit 9 makes distribute a push; low three digits give length.
// - Push stores at pointer-designated word, increments base pointer, updates negative.
// - Condition false: nothing written, flags untouched.
// - Distribute errors on non-BCD control or control between 6655 and 9000.
// - Distribute errors when base and last word sit in different areas.
// - Distribute equal flag shows source is zero.
// - Normal collect copies base plus offset word to destination.
// - Collect top digit 9 reads oldest, 8 reads newest; length from low digits.
// - Oldest-first read copies oldest entry, then pointer drops by one.
// - Newest-first read copies latest entry, then pointer drops by one.
// - Collect errors on non-BCD control or control between 6655 and 8000.
// - Stack collect errors on split areas or pointer above length.
// - Collect equal flag shows transferred word is zero.
// - Bit move copies designated source bit to designated destination bit.
// - Bit move errors on non-BCD designator or bit above 15.
// - After bit move, negative equals destination top bit.
// - Digit move copies up to four digits, wrapping past digit 3.
// - Digit move errors when any low three designator digits exceed 3.
// - Bad indirect pointer (non-BCD or past area end) raises error.
module wdc_unit
  import wdc_pkg::*;
#(
  parameter int DM_WORDS = 6144
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic reqValid,
  output logic reqReady,
  input wire wdc_req_s req,
  output logic doneValid,
  output wdc_flags_s flags,
  output wdc_mem_s mem,
  input wire wdc_word_t memRdata,
  input wire logic memAck,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // Pointer value is BCD, so no area can reach past 9999 words
  if (DM_WORDS < 1 || DM_WORDS > 9999) begin : g_bad_words
    $error("DM_WORDS out of range");
  end

  typedef struct packed {
    wdc_fsm_e fsm;
    wdc_op_e op;
    logic exec;
    logic stack;
    logic lifo;
    wdc_addr_t base;
    wdc_addr_t dest;
    wdc_word_t src;
    wdc_word_t ctrl;
    wdc_word_t len;
    wdc_word_t ptr;
    wdc_word_t idx;
    wdc_word_t data;
    wdc_mem_s mem;
    wdc_flags_s flags;
    logic [3:0] areaShift;
    logic busAck;
    logic [31:0] busRdata;
  } wdc_state_s;

  wdc_state_s st;
  wdc_state_s n;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic isBcd(input wdc_word_t w);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (w[4*k +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  function automatic logic [13:0] bcdBin(input wdc_word_t w);
    return 14'(w[15:12]) * 14'h03E8 + 14'(w[11:8]) * 14'h0064 + 14'(w[7:4]) * 14'h000A + 14'(w[3:0]);
  endfunction

  // Areas are aligned blocks of 2**shift words; carry out of the map is always a split
  function automatic logic sameArea(input logic [16:0] a, input logic [16:0] b, input logic [3:0] sh);
    return !b[16] && ((a >> sh) == (b >> sh));
  endfunction

  function automatic wdc_word_t digitMove(input wdc_word_t s, input wdc_word_t d, input wdc_word_t di);
    wdc_word_t r;
    logic [1:0] sp;
    logic [1:0] dp;
    r = d;
    for (int k = 0; k < 4; k++) begin
      sp = 2'(di[1:0] + 2'(k));
      dp = 2'(di[9:8] + 2'(k));
      if (k <= int'(di[5:4])) begin
        r[4*dp +: 4] = s[4*sp +: 4];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic accept;
  logic ctrlBcd;
  logic [3:0] topDigit;
  logic [13:0] offVal;
  logic [13:0] lenVal;
  logic indErr;
  logic pushMode;
  logic popMode;
  logic distBad;
  logic collBad;
  logic bitBad;
  logic digitBad;
  logic [16:0] baseExt;
  logic [16:0] lastNormal;
  logic [16:0] lastStack;
  logic [3:0] srcBit;
  logic [3:0] dstBit;

  assign reqReady = (st.fsm == ST_IDLE);
  assign accept = reqValid && reqReady;
  assign doneValid = (st.fsm == ST_DONE);
  assign ctrlBcd = isBcd(req.ctrl);
  assign topDigit = req.ctrl[15:12];
  assign offVal = bcdBin(req.ctrl);
  assign lenVal = bcdBin({4'h0, req.ctrl[11:0]});
  assign baseExt = {1'b0, req.base};
  assign lastNormal = baseExt + 17'(offVal);
  assign lastStack = baseExt + 17'(lenVal);
  assign indErr = req.indUse && (!isBcd(req.indPtr) || int'(bcdBin(req.indPtr)) >= DM_WORDS);
  assign pushMode = (topDigit == `WDC_TOP_FIFO);
  assign popMode = (topDigit == `WDC_TOP_FIFO) || (topDigit == `WDC_TOP_LIFO);
  assign distBad = !ctrlBcd || (req.ctrl > `WDC_NORMAL_MAX && req.ctrl < `WDC_PUSH_MIN)
    || !sameArea(baseExt, pushMode ? lastStack : lastNormal, st.areaShift);
  assign collBad = !ctrlBcd || (req.ctrl > `WDC_NORMAL_MAX && req.ctrl < `WDC_POP_MIN)
    || !sameArea(baseExt, popMode ? lastStack : lastNormal, st.areaShift);
  assign bitBad = !ctrlBcd || req.ctrl[7:0] > `WDC_BIT_MAX || req.ctrl[15:8] > `WDC_BIT_MAX;
  assign digitBad = req.ctrl[3:0] > `WDC_DIGIT_MAX || req.ctrl[7:4] > `WDC_DIGIT_MAX
    || req.ctrl[11:8] > `WDC_DIGIT_MAX;
  assign srcBit = 4'(st.ctrl[7:4] * 4'hA + st.ctrl[3:0]);
  assign dstBit = 4'(st.ctrl[15:12] * 4'hA + st.ctrl[11:8]);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    wdc_word_t bitWord;
    // Built on the destination word as it arrives from memory
    bitWord = memRdata;
    bitWord[dstBit] = st.src[srcBit];
    n = st;
    case (st.fsm)
      ST_IDLE: begin
        if (accept) begin
          n.op = req.op;
          n.exec = req.cond;
          n.base = req.base;
          n.dest = req.dest;
          n.src = req.src;
          n.ctrl = req.ctrl;
          n.len = 16'(lenVal);
          n.lifo = (topDigit == `WDC_TOP_LIFO);
          n.stack = 1'b0;
          n.fsm = ST_DONE;
          if (!req.cond) begin
            n.fsm = ST_DONE;
          end else if (indErr) begin
            n.flags.err = 1'b1;
          end else begin
            case (req.op)
              WDC_WORD_DISTRIBUTE: begin
                if (distBad) begin
                  n.flags.err = 1'b1;
                end else if (pushMode) begin
                  n.stack = 1'b1;
                  n.fsm = ST_RD_PTR;
                  n.mem = '{req: 1'b1, we: 1'b0, addr: req.base, wdata: 16'h0000};
                end else begin
                  n.data = req.src;
                  n.fsm = ST_WR_WORD;
                  n.mem = '{req: 1'b1, we: 1'b1, addr: lastNormal[15:0], wdata: req.src};
                end
              end
              WDC_WORD_COLLECT: begin
                if (collBad) begin
                  n.flags.err = 1'b1;
                end else if (popMode) begin
                  n.stack = 1'b1;
                  n.fsm = ST_RD_PTR;
                  n.mem = '{req: 1'b1, we: 1'b0, addr: req.base, wdata: 16'h0000};
                end else begin
                  n.fsm = ST_RD_WORD;
                  n.mem = '{req: 1'b1, we: 1'b0, addr: lastNormal[15:0], wdata: 16'h0000};
                end
              end
              WDC_BIT_MOVE: begin
                if (bitBad) begin
                  n.flags.err = 1'b1;
                end else begin
                  n.fsm = ST_RD_WORD;
                  n.mem = '{req: 1'b1, we: 1'b0, addr: req.dest, wdata: 16'h0000};
                end
              end
              default: begin
                if (digitBad) begin
                  n.flags.err = 1'b1;
                end else begin
                  n.fsm = ST_RD_WORD;
                  n.mem = '{req: 1'b1, we: 1'b0, addr: req.dest, wdata: 16'h0000};
                end
              end
            endcase
          end
        end
      end
      ST_RD_PTR: begin
        if (memAck) begin
          n.ptr = memRdata;
          n.mem.req = 1'b0;
          n.fsm = ST_DONE;
          if (st.op == WDC_WORD_DISTRIBUTE) begin
            // Full stack refused so the pointer never leaves the stack
            if (memRdata >= st.len) begin
              n.flags.err = 1'b1;
            end else begin
              n.data = st.src;
              n.fsm = ST_WR_WORD;
              n.mem = '{req: 1'b1, we: 1'b1, addr: 16'(st.base + memRdata + 16'h0001), wdata: st.src};
            end
          end else if (memRdata > st.len || memRdata == 16'h0000) begin
            n.flags.err = 1'b1;
          end else begin
            n.fsm = ST_RD_WORD;
            n.mem.req = 1'b1;
            n.mem.we = 1'b0;
            n.mem.addr = st.lifo ? 16'(st.base + memRdata) : 16'(st.base + 16'h0001);
          end
        end
      end
      ST_RD_WORD: begin
        if (memAck) begin
          n.fsm = ST_WR_WORD;
          n.mem.we = 1'b1;
          n.mem.addr = st.dest;
          case (st.op)
            WDC_BIT_MOVE: begin
              n.data = bitWord;
            end
            WDC_DIGIT_MOVE: begin
              n.data = digitMove(st.src, memRdata, st.ctrl);
            end
            default: begin
              n.data = memRdata;
            end
          endcase
          n.mem.wdata = n.data;
        end
      end
      ST_SHIFT_RD: begin
        if (memAck) begin
          // Data keeps the transferred word; shifted words pass straight through
          n.fsm = ST_SHIFT_WR;
          n.mem = '{req: 1'b1, we: 1'b1, addr: 16'(st.base + st.idx), wdata: memRdata};
        end
      end
      ST_SHIFT_WR: begin
        if (memAck) begin
          n.idx = 16'(st.idx + 16'h0001);
          if (n.idx == st.ptr) begin
            n.fsm = ST_WR_PTR;
            n.mem = '{req: 1'b1, we: 1'b1, addr: st.base, wdata: 16'(st.ptr - 16'h0001)};
          end else begin
            n.fsm = ST_SHIFT_RD;
            n.mem = '{req: 1'b1, we: 1'b0, addr: 16'(st.base + n.idx + 16'h0001), wdata: 16'h0000};
          end
        end
      end
      ST_WR_WORD: begin
        if (memAck) begin
          n.mem.req = 1'b0;
          n.fsm = ST_DONE;
          n.flags.err = 1'b0;
          if (st.op == WDC_WORD_DISTRIBUTE || st.op == WDC_WORD_COLLECT) begin
            n.flags.eq = (st.data == 16'h0000);
          end
          if (st.op == WDC_BIT_MOVE) begin
            n.flags.neg = st.data[15];
          end
          if (st.stack && st.op == WDC_WORD_DISTRIBUTE) begin
            n.fsm = ST_WR_PTR;
            n.mem = '{req: 1'b1, we: 1'b1, addr: st.base, wdata: 16'(st.ptr + 16'h0001)};
            n.flags.neg = n.mem.wdata[15];
          end else if (st.stack && !st.lifo && st.ptr > 16'h0001) begin
            // Oldest-first read closes the gap by moving every later entry down one word
            n.idx = 16'h0001;
            n.fsm = ST_SHIFT_RD;
            n.mem = '{req: 1'b1, we: 1'b0, addr: 16'(st.base + 16'h0002), wdata: 16'h0000};
          end else if (st.stack) begin
            n.fsm = ST_WR_PTR;
            n.mem = '{req: 1'b1, we: 1'b1, addr: st.base, wdata: 16'(st.ptr - 16'h0001)};
          end
        end
      end
      ST_WR_PTR: begin
        if (memAck) begin
          n.mem.req = 1'b0;
          n.fsm = ST_DONE;
        end
      end
      ST_DONE: begin
        n.fsm = ST_IDLE;
      end
      default: begin
        n.fsm = ST_IDLE;
      end
    endcase

    // Avalon slave, one wait state on every access
    n.busAck = (avs_read || avs_write) && !st.busAck;
    if (n.busAck && avs_read) begin
      case (avs_address)
        `WDC_ADDR_STATUS: begin
          n.busRdata = 32'h0000_0000;
          n.busRdata[`WDC_STAT_ERR] = st.flags.err;
          n.busRdata[`WDC_STAT_EQ] = st.flags.eq;
          n.busRdata[`WDC_STAT_NEG] = st.flags.neg;
          n.busRdata[`WDC_STAT_BUSY] = (st.fsm != ST_IDLE);
        end
        `WDC_ADDR_CONFIG: begin
          n.busRdata = {28'h000_0000, st.areaShift};
        end
        default: begin
          n.busRdata = 32'h0000_0000;
        end
      endcase
    end
    if (avs_write && st.busAck && avs_address == `WDC_ADDR_CONFIG) begin
      n.areaShift = avs_writedata[3:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.fsm <= ST_IDLE;
      st.areaShift <= `WDC_CFG_SHIFT_RST;
    end else begin
      st <= n;
    end
  end

  assign flags = st.flags;
  assign mem = st.mem;
  assign avs_readdata = st.busRdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st.busAck;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  wdc_addr_t expAddr;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      expAddr <= 16'h0000;
    end else if (accept) begin
      expAddr <= lastNormal[15:0];
    end
  end

  a_cond_noop: assert property (@(posedge clk) disable iff (!resetn)
    accept && !req.cond |=> doneValid && !mem.req && $stable(flags))
    else $error("false condition did work");

  a_dist_ctrl: assert property (@(posedge clk) disable iff (!resetn)
    accept && req.cond && req.op == WDC_WORD_DISTRIBUTE && ctrlBcd
    && req.ctrl > 16'h6655 && req.ctrl < 16'h9000 |=> doneValid && flags.err)
    else $error("distribute range error missed");

  a_coll_ctrl: assert property (@(posedge clk) disable iff (!resetn)
    accept && req.cond && req.op == WDC_WORD_COLLECT && !ctrlBcd |=> doneValid && flags.err)
    else $error("collect BCD error missed");

  a_bit_range: assert property (@(posedge clk) disable iff (!resetn)
    accept && req.cond && !indErr && req.op == WDC_BIT_MOVE && req.ctrl[7:0] == 8'h16 |=> doneValid && flags.err)
    else $error("bit range error missed");

  a_digit_range: assert property (@(posedge clk) disable iff (!resetn)
    accept && req.cond && req.op == WDC_DIGIT_MOVE && req.ctrl[11:8] == 4'h4 |=> doneValid && flags.err ##1 !mem.req)
    else $error("digit range not refused");

  a_ind_error: assert property (@(posedge clk) disable iff (!resetn)
    accept && req.cond && indErr |=> doneValid && flags.err && !mem.req)
    else $error("indirect error missed");

  a_dist_addr: assert property (@(posedge clk) disable iff (!resetn)
    st.fsm == ST_WR_WORD && st.op == WDC_WORD_DISTRIBUTE && !st.stack |-> mem.we && mem.addr == expAddr)
    else $error("distribute address wrong");

  a_push_ptr: assert property (@(posedge clk) disable iff (!resetn)
    st.fsm == ST_WR_PTR && st.op == WDC_WORD_DISTRIBUTE |-> mem.addr == st.base && mem.wdata == 16'(st.ptr + 16'h0001))
    else $error("push pointer wrong");

  a_pop_ptr: assert property (@(posedge clk) disable iff (!resetn)
    st.fsm == ST_WR_PTR && st.op == WDC_WORD_COLLECT |-> mem.wdata == 16'(st.ptr - 16'h0001))
    else $error("pop pointer wrong");

  a_eq_flag: assert property (@(posedge clk) disable iff (!resetn)
    doneValid && st.exec && !flags.err && st.op == WDC_WORD_COLLECT |-> flags.eq == (st.data == 16'h0000))
    else $error("collect equal flag wrong");

  a_neg_bit: assert property (@(posedge clk) disable iff (!resetn)
    doneValid && st.exec && !flags.err && st.op == WDC_BIT_MOVE |-> flags.neg == st.data[15])
    else $error("bit move negative wrong");

  a_mem_hold: assert property (@(posedge clk) disable iff (!resetn)
    mem.req && !memAck |=> mem.req && $stable(mem.addr) && $stable(mem.we))
    else $error("memory request dropped");

endmodule

`default_nettype wire

// ==== bench/wdc_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdc_mem_model
  import wdc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire wdc_mem_s mem,
  input wire logic slow,
  output logic [15:0] memRdata,
  output logic memAck
);
  logic [15:0] m [0:65535];
  logic [1:0] waitCnt;
  // ----------------------------------------
  // Data areas: one access per ack
  // ----------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      memAck <= 1'b0;
      waitCnt <= 2'h0;
      memRdata <= 16'h0000;
    end else begin
      memAck <= 1'b0;
      // Stale data toggles so it never passes as valid
      memRdata <= ~memRdata;
      if (mem.req && !memAck) begin
        if (waitCnt != 2'h0) begin
          waitCnt <= waitCnt - 2'h1;
        end else begin
          memAck <= 1'b1;
          waitCnt <= slow ? 2'h3 : 2'h0;
          if (mem.we) begin
            m[mem.addr] <= mem.wdata;
          end else begin
            memRdata <= m[mem.addr];
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "wdc_regs.svh"
module testbench
  import wdc_pkg::*;
;
  localparam int DMW = 6144;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic reqValid = 1'b0;
  logic slow = 1'b0;
  logic reqReady, doneValid, memAck, avs_waitrequest;
  wdc_req_s req = '0;
  wdc_flags_s flags, expF;
  wdc_mem_s mem;
  wdc_word_t memRdata;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, rd;
  logic [15:0] expm [0:65535];
  int error_cnt = 0;
  int n_compared = 0;
  int seed = 32'habb6;
  int sh = 12;

  wdc_unit #(.DM_WORDS(DMW)) dut_u (.clk, .resetn, .reqValid, .reqReady, .req, .doneValid, .flags, .mem,
    .memRdata, .memAck, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  wdc_mem_model mem_u (.clk, .resetn, .mem, .slow, .memRdata, .memAck);

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic finish_test();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic int rm(input int n);
    return {$random(seed)} % n;
  endfunction

  function automatic logic isbcd(input logic [15:0] v);
    return v[3:0] < 10 && v[7:4] < 10 && v[11:8] < 10 && v[15:12] < 10;
  endfunction

  function automatic int bv(input logic [15:0] v);
    return v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
  endfunction

  function automatic logic [15:0] tobcd(input int n);
    return {4'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
  endfunction

  function automatic logic split(input int a, input int b);
    return b > 65535 || (a >> sh) != (b >> sh);
  endfunction

  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // ----------------------------------------
  // Reference model
  // ----------------------------------------
  task automatic ref_exec(input wdc_req_s r);
    int c, p, ln, t;
    logic [15:0] v;
    logic e;
    c = bv(r.ctrl);
    p = expm[r.base];
    ln = c % 1000;
    if (!r.cond) return;
    e = r.indUse && (!isbcd(r.indPtr) || bv(r.indPtr) >= DMW);
    case (r.op)
      WDC_WORD_DISTRIBUTE: begin
        if (!isbcd(r.ctrl) || (c > 6655 && c < 9000)) e = 1;
        else if (c <= 6655) begin
          if (split(r.base, r.base + c)) e = 1;
          else if (!e) expm[r.base + c] = r.src;
        end else if (split(r.base, r.base + ln) || p >= ln) e = 1;
        else if (!e) begin
          expm[r.base + p + 1] = r.src;
          expm[r.base] = 16'(p + 1);
          expF.neg = expm[r.base][15];
        end
        if (!e) expF.eq = r.src == 16'h0000;
      end
      WDC_WORD_COLLECT: begin
        if (!isbcd(r.ctrl) || (c > 6655 && c < 8000)) e = 1;
        else if (c <= 6655) begin
          if (split(r.base, r.base + c)) e = 1;
          else v = expm[r.base + c];
        end else if (split(r.base, r.base + ln) || p == 0 || p > ln) e = 1;
        else v = (c >= 9000) ? expm[r.base + 1] : expm[r.base + p];
        if (!e) begin
          expm[r.dest] = v;
          if (c >= 8000) begin
            if (c >= 9000) for (t = 1; t < p; t++) expm[r.base + t] = expm[r.base + t + 1];
            expm[r.base] = 16'(p - 1);
          end
          expF.eq = v == 16'h0000;
        end
      end
      WDC_BIT_MOVE: begin
        if (!isbcd(r.ctrl) || c / 100 > 15 || c % 100 > 15) e = 1;
        else if (!e) begin
          v = expm[r.dest];
          v[c / 100] = r.src[c % 100];
          expm[r.dest] = v;
          expF.neg = v[15];
        end
      end
      default: begin
        if (r.ctrl[3:0] > 3 || r.ctrl[7:4] > 3 || r.ctrl[11:8] > 3) e = 1;
        else if (!e) begin
          v = expm[r.dest];
          for (t = 0; t <= r.ctrl[7:4]; t++) begin
            v[4 * ((r.ctrl[11:8] + t) % 4) +: 4] = r.src[4 * ((r.ctrl[3:0] + t) % 4) +: 4];
          end
          expm[r.dest] = v;
        end
      end
    endcase
    expF.err = e;
  endtask

  // ----------------------------------------
  // Instruction driver and result check
  // ----------------------------------------
  task automatic run(input wdc_req_s r);
    int n;
    n = 0;
    reqValid <= 1'b1;
    req <= r;
    do @(posedge clk); while (reqReady !== 1'b1);
    reqValid <= 1'b0;
    req <= ~r;
    do @(posedge clk); while (doneValid !== 1'b1);
    ref_exec(r);
    chk(32'(flags), 32'(expF));
    for (n = 16'h0F80; n < 16'h1100; n++) chk(32'(mem_u.m[n]), 32'(expm[n]));
  endtask

  task automatic go(input wdc_op_e op, input logic [15:0] s, b, c, d);
    run('{op, 1'b1, s, b, c, d, 1'b0, 16'h0000});
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] dc [8] = '{16'h0005, 16'h0127, 16'h0128, 16'h6655, 16'h6656, 16'h8999, 16'h9A00, 16'h0000};
    logic [15:0] cc [4] = '{16'h0003, 16'h6656, 16'h7999, 16'h00B0};
    logic [15:0] ip [3] = '{16'h6143, 16'h6144, 16'h00A0};
    int op;
    for (int a = 0; a < 65536; a++) begin
      expm[a] = 16'($random(seed));
      mem_u.m[a] = expm[a];
    end
    expm[16'h1000] = 16'h0000;
    mem_u.m[16'h1000] = 16'h0000;
    expF = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    av(1'b0, `WDC_ADDR_CONFIG, 32'h0000_0000);
    chk(rd, 32'h0000_000C);
    av(1'b0, `WDC_ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    av(1'b1, 4'h8, 32'hFFFF_FFFF);
    av(1'b0, 4'h8, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    foreach (dc[i]) go(WDC_WORD_DISTRIBUTE, i == 7 ? 16'h0000 : 16'($random(seed)), 16'h0F80, dc[i], 16'h0000);
    av(1'b0, `WDC_ADDR_STATUS, 32'h0000_0000);
    chk(rd, {29'h0, expF.neg, expF.eq, expF.err});
    run('{WDC_WORD_DISTRIBUTE, 1'b0, 16'h1234, 16'h0F80, 16'h0001, 16'h0000, 1'b0, 16'h0000});
    foreach (ip[i]) run('{WDC_WORD_COLLECT, 1'b1, 16'h0000, 16'h1010, 16'h0002, 16'h1081, 1'b1, ip[i]});
    foreach (cc[i]) go(WDC_WORD_COLLECT, 16'h0000, 16'h1010, cc[i], 16'h1081);
    slow <= 1'b1;
    // Stack length 5 for every push and pop except the last pop, which uses length 2
    repeat (6) go(WDC_WORD_DISTRIBUTE, 16'($random(seed)), 16'h1000, 16'h9005, 16'h0000);
    go(WDC_WORD_DISTRIBUTE, 16'h0001, 16'h0FFE, 16'h9005, 16'h0000);
    repeat (2) go(WDC_WORD_COLLECT, 16'h0000, 16'h1000, 16'h8005, 16'h1080);
    repeat (4) go(WDC_WORD_COLLECT, 16'h0000, 16'h1000, 16'h9005, 16'h1080);
    repeat (3) go(WDC_WORD_DISTRIBUTE, 16'h0000, 16'h1000, 16'h9005, 16'h0000);
    go(WDC_WORD_COLLECT, 16'h0000, 16'h1000, 16'h8002, 16'h1080);
    av(1'b1, `WDC_ADDR_CONFIG, 32'h0000_0004);
    sh = 4;
    go(WDC_WORD_DISTRIBUTE, 16'h00AA, 16'h1008, 16'h0008, 16'h0000);
    go(WDC_WORD_DISTRIBUTE, 16'h00AA, 16'h1008, 16'h0007, 16'h0000);
    av(1'b1, `WDC_ADDR_CONFIG, 32'h0000_000C);
    sh = 12;
    slow <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      go(WDC_BIT_MOVE, 16'($random(seed)), 16'h0000, i == 0 ? 16'h1600 : i == 1 ? 16'h0016 : i == 2 ? 16'h1A00 :
        i == 3 ? 16'h1515 : tobcd(rm(16) * 100 + rm(16)), 16'h1082);
    end
    for (int i = 0; i < 68; i++) begin
      go(WDC_DIGIT_MOVE, 16'($random(seed)), 16'h0000, i < 64 ? {4'(rm(16)), 4'(i / 16), 4'(i / 4 % 4), 4'(i % 4)} :
        16'h0004 << 4 * (i - 64), 16'h1083);
    end
    for (int i = 0; i < 40; i++) begin
      op = rm(4);
      slow <= 1'(rm(2));
      run('{wdc_op_e'(op), rm(8) != 0, 16'($random(seed)), 16'(16'h1040 + rm(32)),
        op < 2 ? tobcd(rm(64)) : op == 2 ? tobcd(rm(17) * 100 + rm(17)) : 16'(rm(65536)) & 16'h0777,
        16'(16'h1090 + rm(16)), 1'(rm(2)), tobcd(6140 + rm(8))});
    end
    finish_test();
  end
endmodule
`default_nettype wire
